// >>> rtl/fps_pkg.sv
/*
 * shared constants and types for the flash protection, status and pause block.
 * assumes a 10 MHz system clock and a serial clock arriving from the host.
 */
package fps_pkg;

    localparam int STAT_W       = 8;
    localparam int ADDR_W       = 20;
    localparam int BP_W         = 3;
    localparam int OP_W         = 8;
    localparam int FRAME_BITS   = 16;
    localparam int CNT_W        = 5;

    // status bit positions
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_WEL_BIT   = 1;
    localparam int ST_BP_LSB    = 2;
    localparam int ST_RSV_BIT   = 5;
    localparam int ST_AAI_BIT   = 6;
    localparam int ST_LOCK_BIT  = 7;

    // power-up values
    localparam logic [BP_W-1:0] BP_RST   = 3'h7;
    localparam logic            LOCK_RST = 1'b0;
    localparam logic            RSV_VAL  = 1'b0;

    localparam logic [OP_W-1:0] STATUS_WRITE_OP = 8'h01;

    // lowest protected address for each protection code
    localparam logic [ADDR_W-1:0] PROT_BASE_1  = 20'hf0000;
    localparam logic [ADDR_W-1:0] PROT_BASE_2  = 20'he0000;
    localparam logic [ADDR_W-1:0] PROT_BASE_4  = 20'hc0000;
    localparam logic [ADDR_W-1:0] PROT_BASE_8  = 20'h80000;
    localparam logic [ADDR_W-1:0] PROT_BASE_ALL = 20'h00000;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
    } fps_pins_t;

    typedef struct packed {
        logic busy;
        logic write_enable_latch;
        logic auto_increment_program_flag;
    } fps_engine_t;

    typedef enum logic {HS_RUN, HS_HELD} fps_hold_t;

endpackage

// >>> rtl/fps_protect_status.sv
/*
 * protection code, lock bit, status byte, chip-erase gate and pause (hold) control.
 * assumes: instruction engine on sys_clk supplies busy/latch/auto-increment flags
 * and erase requests; the host drives the serial pins, sck also clocks the link side.
 */
// What this block does
// - protection code selects the shielded upper part of the array
// - status write may change protection only if wp pin high or lock zero
// - chip erase refused unless protection code is all zero
// - power-up sets all three protection bits to one
// - wp low and lock one freeze lock and protection bits
// - wp high makes lock bit irrelevant to status writes
// - power-up clears the lock bit
// - pause entered when hold falls with sck low, chip select low
// - hold falling with sck high enters pause at next sck low
// - pause left when hold rises with sck low, else at next low
// - paused: serial output floats, serial input and clock ignored
// - chip select high while paused resets the interface logic
// - pause lasts while hold low and select low; resume needs hold high, select low
// - status write rejected only for wp low and lock one
// - lock bit lives at status bit 7
// - status bit 0 shows internal program or erase in progress
// - status bit 1 shows write enable latch
// - protection bits at status bits 2..4, reset one, writable
// - status bit 6 shows auto-increment programming mode
// - writes alter only protection and lock; bit 5 reads zero
// - all status bits volatile, defaults restored at power-up
// - codes 000 none, 001..100 top 1/2/4/8 blocks, 101..111 all
`timescale 1ns/10ps
module fps_protect_status
    import fps_pkg::*;
(
    // system
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // serial pins
    input  wire logic                  sck,
    input  wire fps_pins_t             pin_i,
    output logic                       so_o,
    output logic                       so_oe,
    // read path
    input  wire logic                  so_data_i,
    input  wire logic                  so_drive_i,
    // engine side
    input  wire fps_engine_t           eng_i,
    input  wire logic                  erase_req,
    output logic                       chip_erase_ok,
    output logic                       chip_erase_refused,
    input  wire logic [ADDR_W-1:0]     chk_addr,
    output logic                       addr_protected,
    // status and events
    output logic [STAT_W-1:0]          status_q,
    output logic                       status_write_cmd_done,
    output logic                       status_write_cmd_rejected,
    output logic                       held,
    output logic                       if_reset
);

    // protection code to lowest protected address
    function automatic logic [ADDR_W-1:0] prot_base(input logic [BP_W-1:0] code);
        logic [ADDR_W-1:0] b;
        b = PROT_BASE_ALL;
        unique case (code)
            3'h1: b = PROT_BASE_1;
            3'h2: b = PROT_BASE_2;
            3'h3: b = PROT_BASE_4;
            3'h4: b = PROT_BASE_8;
            default: b = PROT_BASE_ALL;
        endcase
        return b;
    endfunction

    function automatic logic is_protected(input logic [BP_W-1:0] code, input logic [ADDR_W-1:0] a);
        return (code != 3'h0) && (a >= prot_base(code));
    endfunction

    // link side, clocked by sck
    logic                link_rst_n;
    logic [CNT_W-1:0]    bit_cnt_q;
    logic [OP_W-1:0]     shift_q;
    logic [OP_W-1:0]     op_byte_q;
    logic [OP_W-1:0]     dat_byte_q;
    logic                pair_tgl_q;
    logic                link_take;
    logic [OP_W-1:0]     shift_d;

    assign link_rst_n = rst_n & ~pin_i.cs_n;
    assign link_take  = pin_i.hold_n && (bit_cnt_q < CNT_W'(FRAME_BITS));
    assign shift_d    = {shift_q[OP_W-2:0], pin_i.si};

    // bit counter cleared whenever chip select is high
    always_ff @(posedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_q <= '0;
            shift_q   <= '0;
        end else if (link_take) begin
            bit_cnt_q <= bit_cnt_q + CNT_W'(1);
            shift_q   <= shift_d;
        end
    end

    // opcode and first data byte held until the next frame
    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            op_byte_q  <= '0;
            dat_byte_q <= '0;
            pair_tgl_q <= 1'b0;
        end else if (link_take && !pin_i.cs_n && bit_cnt_q == CNT_W'(OP_W - 1)) begin
            op_byte_q  <= shift_d;
        end else if (link_take && !pin_i.cs_n && bit_cnt_q == CNT_W'(FRAME_BITS - 1)) begin
            dat_byte_q <= shift_d;
            pair_tgl_q <= ~pair_tgl_q;
        end
    end

    // pin and toggle synchronisers
    logic [4:0]  pin_s1_q;
    logic [4:0]  pin_s2_q;
    logic        tgl_s1_q;
    logic        tgl_s2_q;
    logic        tgl_s3_q;
    logic        cs_s3_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 5'h17;
            pin_s2_q <= 5'h17;
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
            cs_s3_q  <= 1'b1;
        end else begin
            pin_s1_q <= {pin_i.cs_n, pin_i.sck, pin_i.si, pin_i.hold_n, pin_i.wp_n};
            pin_s2_q <= pin_s1_q;
            tgl_s1_q <= pair_tgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
            cs_s3_q  <= pin_s2_q[4];
        end
    end

    logic cs_s;
    logic sck_s;
    logic hold_s;
    logic wp_s;
    logic pair_evt;

    assign cs_s     = pin_s2_q[4];
    assign sck_s    = pin_s2_q[3];
    assign hold_s   = pin_s2_q[1];
    assign wp_s     = pin_s2_q[0];
    assign pair_evt = tgl_s2_q ^ tgl_s3_q;

    // pause control
    fps_hold_t  hold_st_q;
    fps_hold_t  hold_st_d;
    logic       cs_rise;

    assign cs_rise = cs_s && !cs_s3_q;

    always_comb begin
        hold_st_d = hold_st_q;
        unique case (hold_st_q)
            HS_RUN: begin
                if (!cs_s && !sck_s && !hold_s) begin
                    hold_st_d = HS_HELD;
                end
            end
            HS_HELD: begin
                if (cs_s) begin
                    hold_st_d = HS_RUN;
                end else if (!sck_s && hold_s) begin
                    hold_st_d = HS_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_st_q <= HS_RUN;
            if_reset  <= 1'b0;
            so_o      <= 1'b0;
            so_oe     <= 1'b0;
        end else begin
            hold_st_q <= hold_st_d;
            if_reset  <= (hold_st_q == HS_HELD) && cs_s;
            so_o      <= so_data_i;
            so_oe     <= so_drive_i && (hold_st_d == HS_RUN);
        end
    end

    assign held = (hold_st_q == HS_HELD);

    // status write decode
    logic [BP_W-1:0]  bp_q;
    logic             lock_q;
    logic             is_wr;
    logic             wr_allowed;
    logic             wr_ok;
    logic             wr_bad;

    assign is_wr      = pair_evt && (op_byte_q == STATUS_WRITE_OP);
    assign wr_allowed = wp_s || !lock_q;
    assign wr_ok      = is_wr && wr_allowed;
    assign wr_bad     = is_wr && !wr_allowed;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bp_q   <= BP_RST;
            lock_q <= LOCK_RST;
        end else if (wr_ok) begin
            bp_q   <= dat_byte_q[ST_BP_LSB +: BP_W];
            lock_q <= dat_byte_q[ST_LOCK_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_write_cmd_done          <= 1'b0;
            status_write_cmd_rejected      <= 1'b0;
            chip_erase_ok      <= 1'b0;
            chip_erase_refused <= 1'b0;
            addr_protected     <= 1'b1;
            status_q           <= {LOCK_RST, 1'b0, RSV_VAL, BP_RST, 2'h0};
        end else begin
            status_write_cmd_done          <= wr_ok;
            status_write_cmd_rejected      <= wr_bad;
            chip_erase_ok      <= erase_req && (bp_q == '0);
            chip_erase_refused <= erase_req && (bp_q != '0);
            addr_protected     <= is_protected(bp_q, chk_addr);
            status_q           <= {lock_q, eng_i.auto_increment_program_flag, RSV_VAL, bp_q,
                                   eng_i.write_enable_latch, eng_i.busy};
        end
    end

    // checks
    sequence s_lock_hit;
        is_wr && !wp_s && lock_q;
    endsequence

    sequence s_pause_request;
        hold_st_q == HS_RUN && !cs_s && !sck_s && !hold_s;
    endsequence

    sequence s_resume_request;
        hold_st_q == HS_HELD && !cs_s && !sck_s && hold_s;
    endsequence

    chk_lock_freeze: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_lock_hit |=> $stable(bp_q) && $stable(lock_q) && status_write_cmd_rejected && !status_write_cmd_done)
        else $error("locked status write changed protection");

    chk_wp_override: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (is_wr && wp_s) |=> status_write_cmd_done && bp_q == $past(dat_byte_q[4:2]) && lock_q == $past(dat_byte_q[7]))
        else $error("status write with wp high not taken");

    chk_unlocked_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (is_wr && !lock_q) |=> status_write_cmd_done ##1 status_q[4:2] == $past(bp_q))
        else $error("unlocked status write not taken");

    chk_bp_only_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !wr_ok |=> $stable(bp_q) && $stable(lock_q))
        else $error("protection changed without accepted write");

    chk_erase_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        erase_req |=> chip_erase_ok == ($past(bp_q) == 3'h0) && chip_erase_refused != chip_erase_ok)
        else $error("chip erase gate wrong");

    chk_status_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 status_q[0] == $past(eng_i.busy) && status_q[1] == $past(eng_i.write_enable_latch)
            && status_q[6] == $past(eng_i.auto_increment_program_flag) && status_q[5] == 1'b0
            && status_q[7] == $past(lock_q))
        else $error("status byte layout wrong");

    chk_protect_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 addr_protected == (($past(bp_q) >= 3'h5) || ($past(bp_q) == 3'h4 && $past(chk_addr[19]))
            || ($past(bp_q) == 3'h3 && $past(chk_addr[19:18]) == 2'h3)
            || ($past(bp_q) == 3'h2 && $past(chk_addr[19:17]) == 3'h7)
            || ($past(bp_q) == 3'h1 && $past(chk_addr[19:16]) == 4'hf)))
        else $error("protected area decode wrong");

    chk_pause_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_pause_request |=> held)
        else $error("pause not entered with sck low");

    chk_pause_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (hold_st_q == HS_RUN && sck_s) |=> !held)
        else $error("pause entered while sck high");

    chk_pause_exit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_resume_request |=> !held ##0 (hold_st_q == HS_RUN))
        else $error("pause not left with sck low");

    chk_pause_stays: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (held && !cs_s && !hold_s) |=> held)
        else $error("pause dropped while hold low");

    chk_so_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
        so_oe |-> hold_st_q == HS_RUN)
        else $error("serial output driven while paused");

    chk_cs_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (held && cs_s) |=> if_reset && !held)
        else $error("chip select high in pause did not reset");

    chk_link_ignore: assert property (@(posedge sck) disable iff (!link_rst_n)
        !pin_i.hold_n |=> $stable(bit_cnt_q) && $stable(shift_q))
        else $error("serial input taken while paused");

    chk_cs_seen: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cs_rise && held) |-> ##1 if_reset)
        else $error("chip select rise in pause missed");

    sequence s_write_taken;
        wr_ok;
    endsequence

    sequence s_write_refused;
        wr_bad;
    endsequence

    chk_erase_exclusive: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(chip_erase_ok && chip_erase_refused))
        else $error("chip erase granted and refused together");

    chk_erase_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !erase_req |=> !chip_erase_ok && !chip_erase_refused)
        else $error("chip erase answer without request");

    chk_full_protect: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (bp_q >= 3'h5) |=> addr_protected)
        else $error("address open although whole array protected");

    chk_no_protect: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (bp_q == 3'h0) |=> !addr_protected)
        else $error("address protected with code zero");

    chk_lock_position: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_write_taken |=> lock_q == $past(dat_byte_q[ST_LOCK_BIT]))
        else $error("lock bit not taken from data bit 7");

    chk_bp_field: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 status_q[4:2] == $past(bp_q))
        else $error("protection field misplaced in status");

    chk_wel_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 status_q[1] == $past(eng_i.write_enable_latch))
        else $error("write enable bit wrong in status");

    chk_aai_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 status_q[6] == $past(eng_i.auto_increment_program_flag))
        else $error("auto-increment bit wrong in status");

    chk_rsv_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_q[5] == 1'b0)
        else $error("reserved status bit set");

    chk_reject_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_write_refused |=> !status_write_cmd_done ##1 $stable(status_q[4:2]) && $stable(status_q[7]))
        else $error("refused status write altered status");

    chk_outcome_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(status_write_cmd_done && status_write_cmd_rejected))
        else $error("status write both done and refused");

    chk_select_needed: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (hold_st_q == HS_RUN && cs_s) |=> !held)
        else $error("pause entered with chip select high");

    chk_held_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        held |-> !so_oe)
        else $error("output enabled while paused");

    chk_reset_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
        if_reset |-> $past(held) && $past(cs_s))
        else $error("interface reset without select in pause");

endmodule

// >>> verification/fps_host_model.sv
/* host model for the flash pins: status-write frames and static pin levels.
   assumes the bench keeps busy low unless it wants the host to wait. */
`timescale 1ns/10ps
module fps_host_model (
    // engine state seen by the host
    input  wire logic busy,
    // serial pins
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n,
    output logic      wp_n
);
    initial begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        si     = 1'b1;
        hold_n = 1'b1;
        wp_n   = 1'b1;
    end
    // opcode then data, msb first; sck stands low outside frames
    task automatic frame(input logic [15:0] bits, input int slow);
        wait (busy === 1'b0);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            si = bits[i];
            #15;
            sck = 1'b1;
            #(15 + slow);
            sck = 1'b0;
        end
        #15;
        cs_n = 1'b1;
        si   = ~si;
        #600;
    endtask
    // static levels for pause tests
    task automatic pins(input logic c, input logic s, input logic h, input logic w);
        cs_n   = c;
        sck    = s;
        #5;
        hold_n = h;
        wp_n   = w;
    endtask
endmodule

// >>> verification/testbench.sv
/* self-checking bench for the protection, status and pause block.
   assumes the host model runs its own sck inside frames, 30 ns per bit plus the slow stretch of the high phase. */
`timescale 1ns/10ps
module testbench;
    import fps_pkg::*;
    logic              sys_clk, rst_n, so_data_i, so_drive_i, erase_req;
    fps_engine_t       eng_i;
    logic [ADDR_W-1:0] chk_addr;
    fps_pins_t         pin_i;
    logic              cs_n, sck, si, hold_n, wp_n;
    logic              so_o, so_oe, ok, refused, prot, done, rej, held, if_reset;
    logic [STAT_W-1:0] status_q;
    logic [7:0]        st_exp;
    int                fails, n_tests;

    assign pin_i = {cs_n, sck, si, hold_n, wp_n};
    fps_host_model host (.busy(eng_i.busy), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n));
    fps_protect_status DUT (.sys_clk(sys_clk), .rst_n(rst_n), .sck(sck), .pin_i(pin_i), .so_o(so_o),
        .so_oe(so_oe), .so_data_i(so_data_i), .so_drive_i(so_drive_i), .eng_i(eng_i), .erase_req(erase_req),
        .chip_erase_ok(ok), .chip_erase_refused(refused), .chk_addr(chk_addr), .addr_protected(prot),
        .status_q(status_q), .status_write_cmd_done(done), .status_write_cmd_rejected(rej), .held(held), .if_reset(if_reset));

    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;

    task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic t_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(3);
        #1;
        st_exp = 8'h1c;
        check("status after reset", status_q, 8'h1c);
        check("protected after reset", prot, 1'b1);
        check("held after reset", held, 1'b0);
    endtask
    task automatic t_engine();
        logic [7:0] mask [3] = '{8'h01, 8'h02, 8'h40};
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            eng_i <= fps_engine_t'(3'b100 >> i);
            cyc(3);
            #1;
            check("engine bit", status_q, 8'h1c | mask[i]);
            eng_i <= '0;
        end
        cyc(3);
    endtask
    task automatic t_erase(input logic exp_ok);
        logic o;
        logic r;
        o = 1'b0;
        r = 1'b0;
        @(posedge sys_clk);
        erase_req <= 1'b1;
        @(posedge sys_clk);
        erase_req <= 1'b0;
        repeat (3) begin
            #1;
            o |= ok;
            r |= refused;
            @(posedge sys_clk);
        end
        check("erase ok", o, exp_ok);
        check("erase refused", r, !exp_ok);
    endtask
    task automatic wr_status(input logic [7:0] d, input logic wp, input logic exp_rej, input int slow);
        logic sd;
        logic sr;
        sd = 1'b0;
        sr = 1'b0;
        host.pins(1'b1, 1'b0, 1'b1, wp);
        fork
            host.frame({STATUS_WRITE_OP, d}, slow);
            repeat (60) begin
                @(posedge sys_clk);
                #1;
                sd |= done;
                sr |= rej;
            end
        join
        check("write rejected", sr, exp_rej);
        check("write done", sd, !exp_rej);
        if (!exp_rej) begin
            st_exp = {d[7], 2'b00, d[4:2], 2'b00};
        end
        check("status byte", status_q, st_exp);
    endtask
    task automatic t_decode();
        logic [ADDR_W-1:0] a [10] = '{20'h00000, 20'h7ffff, 20'h80000, 20'hbffff, 20'hc0000,
                                      20'hdffff, 20'he0000, 20'hefff0, 20'hf0000, 20'hfffff};
        logic [ADDR_W-1:0] bs [8] = '{20'h00000, 20'hf0000, 20'he0000, 20'hc0000, 20'h80000,
                                      20'h00000, 20'h00000, 20'h00000};
        for (int c = 0; c < 8; c++) begin
            wr_status({3'b011, c[2:0], 2'b11}, 1'b1, 1'b0, (c % 2) * 40);
            t_erase(c == 0);
            for (int j = 0; j < 10; j++) begin
                @(posedge sys_clk);
                chk_addr <= a[j];
                @(posedge sys_clk);
                #1;
                check("protected", prot, c != 0 && a[j] >= bs[c]);
            end
        end
    endtask
    task automatic t_lock();
        wr_status(8'h80, 1'b0, 1'b0, 0);
        wr_status(8'h9c, 1'b0, 1'b1, 0);
        wr_status(8'h00, 1'b0, 1'b1, 30);
        t_erase(1'b1);
        wr_status(8'h8c, 1'b1, 1'b0, 0);
        t_erase(1'b0);
    endtask
    task automatic hold_step(input logic s, input logic h, input logic exp);
        host.pins(1'b0, s, h, 1'b1);
        cyc(5);
        #1;
        check("held", held, exp);
    endtask
    task automatic t_hold();
        logic ir;
        ir = 1'b0;
        @(posedge sys_clk);
        so_drive_i <= 1'b1;
        so_data_i  <= 1'b1;
        hold_step(1'b0, 1'b1, 1'b0);
        check("output enable", so_oe, 1'b1);
        check("serial out", so_o, 1'b1);
        hold_step(1'b0, 1'b0, 1'b1);
        check("output enable", so_oe, 1'b0);
        hold_step(1'b0, 1'b1, 1'b0);
        hold_step(1'b1, 1'b0, 1'b0);
        hold_step(1'b0, 1'b0, 1'b1);
        hold_step(1'b1, 1'b0, 1'b1);
        hold_step(1'b0, 1'b0, 1'b1);
        hold_step(1'b1, 1'b1, 1'b1);
        hold_step(1'b0, 1'b1, 1'b0);
        hold_step(1'b0, 1'b0, 1'b1);
        host.pins(1'b1, 1'b0, 1'b0, 1'b1);
        repeat (6) begin
            @(posedge sys_clk);
            #1;
            ir |= if_reset;
        end
        check("interface reset", ir, 1'b1);
        check("held after select", held, 1'b0);
        host.pins(1'b1, 1'b0, 1'b1, 1'b1);
        so_drive_i <= 1'b0;
    endtask

    initial begin
        rst_n      = 1'b0;
        so_data_i  = 1'b0;
        so_drive_i = 1'b0;
        erase_req  = 1'b0;
        eng_i      = '0;
        chk_addr   = '0;
        st_exp     = 8'h1c;
        t_reset();
        t_engine();
        t_erase(1'b0);
        t_decode();
        t_lock();
        t_hold();
        t_reset();
        finish_test();
    end
    initial begin
        #1ms;
        fails++;
        finish_test();
    end
endmodule
